/* File: hrs_sequencer.sv */
// Purpose : Start-up, attach and bus-reset sequencing for a four-port hub
// Assumes : Single 40 MHz clock; all pins synchronous; APB register access
// Notes   : Long time limits are parameters so simulation can shorten them
//
// Register access over APB and the register addresses are this design's own decisions.

`timescale 1ns/10ps
`default_nettype none

// Contract
// - Start memory load right after recovery
// - Memory load finishes within 99.5 ms
// - Attach within 100 ms after memory load
// - Every host request completes within 5 ms
// - Self-powered SMBus load has no limit
// - Attach within 100 ms after SMBus load
// - Bus reset clears device address to zero
// - Bus reset returns hub to unconfigured
// - Bus reset drops all port power enables
// - Bus reset flushes translator buffers
// - Bus reset wakes a suspended hub
// - Bus reset is not sent downstream
// - Test chain output drives green indicator two
// - Chain output toggles per pin change
module hrs_sequencer #(
	parameter int unsigned RECOVERY_CYC   = hrs_pkg::RECOVERY_CYC,
	parameter int unsigned LOAD_MAX_CYC   = hrs_pkg::LOAD_MAX_CYC,
	parameter int unsigned ATTACH_MAX_CYC = hrs_pkg::ATTACH_MAX_CYC,
	parameter int unsigned REQ_MAX_CYC    = hrs_pkg::REQ_MAX_CYC,
	parameter int unsigned N_TEST         = 24
) (
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              factory_test_pin,
	input  wire logic [1:0]        cfg_sel,
	input  wire logic              sclk_in,
	input  wire logic [N_TEST-1:0] test_pins,
	input  wire logic              mem_load_done,
	input  wire logic              usb_bus_reset,
	input  wire logic              set_addr_stb,
	input  wire logic [6:0]        set_addr_val,
	input  wire logic              set_config_stb,
	input  wire logic [3:0]        port_power_req,
	input  wire logic              suspend_req,
	input  wire logic              req_start,
	input  wire logic              req_done,
	input  wire logic              led_green_two,
	output var  logic              mem_load_start,
	output var  logic              upstream_pullup_en,
	output var  logic [4:1]        port_power_enable,
	output var  logic              tt_flush,
	output var  logic              req_abort,
	output var  logic [6:0]        dev_address,
	output var  logic              green_indicator_two
);

	hrs_pkg::hrs_state_t state_reg, state_next;
	hrs_pkg::hrs_mode_t  mode_reg, mode_next;
	logic [31:0] timer_reg, timer_next;
	logic [31:0] req_tmr_reg, req_tmr_next;
	logic        req_busy_reg, req_busy_next;
	logic        released_reg, released_next;
	logic        start_reg, start_next;
	logic        pullup_reg, pullup_next;
	logic [4:1]  pwr_reg, pwr_next;
	logic        flush_reg, flush_next;
	logic        abort_reg, abort_next;
	logic [6:0]  addr_reg, addr_next;
	logic        cfgd_reg, cfgd_next;
	logic        susp_reg, susp_next;
	logic        busrst_d_reg, busrst_d_next;
	logic        green_reg, green_next;
	logic        load_to_reg, load_to_next;
	logic        req_to_reg, req_to_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        ready_reg, ready_next;
	logic        err_reg, err_next;
	logic        chain_q;
	logic        wr_acc, hit, smb_done_wr, bus_rst_edge;

	// ------------------------------------------------------------
	// Continuity chain
	// ------------------------------------------------------------
	hrs_xnor_chain #(.N(N_TEST)) u_chain (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.test_pins (test_pins),
		.chain_out (chain_q)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Write takes effect at the access edge only
	assign wr_acc       = psel & penable & pwrite & ready_reg;
	assign hit          = (paddr == hrs_pkg::CTRL_OFS) || (paddr == hrs_pkg::STAT_OFS);
	assign smb_done_wr  = wr_acc && paddr == hrs_pkg::CTRL_OFS && pwdata[hrs_pkg::CTRL_SMB_DONE];
	assign bus_rst_edge = usb_bus_reset & ~busrst_d_reg;

	// Setup cycle loads read data, so pready and prdata both come from flops
	always_comb begin
		ctrl_next  = ctrl_reg;
		ready_next = psel & ~penable;
		err_next   = psel & ~penable & ~hit;
		rdata_next = rdata_reg;
		if (psel && !penable) begin
			rdata_next = 32'h0000_0000;
			if (paddr == hrs_pkg::CTRL_OFS) begin
				rdata_next[hrs_pkg::CTRL_SELF_PWR] = ctrl_reg[hrs_pkg::CTRL_SELF_PWR];
			end else if (paddr == hrs_pkg::STAT_OFS) begin
				rdata_next[hrs_pkg::STAT_LOAD_TO]   = load_to_reg;
				rdata_next[hrs_pkg::STAT_REQ_TO]    = req_to_reg;
				rdata_next[hrs_pkg::STAT_ATTACHED]  = pullup_reg;
				rdata_next[hrs_pkg::STAT_CONFIGURED] = cfgd_reg;
				rdata_next[hrs_pkg::STAT_SUSPENDED] = susp_reg;
				rdata_next[hrs_pkg::STAT_TEST]      = (state_reg == hrs_pkg::ST_TEST);
				rdata_next[hrs_pkg::STAT_MODE_LSB +: 2]  = mode_reg;
				rdata_next[hrs_pkg::STAT_STATE_LSB +: 3] = state_reg;
				rdata_next[hrs_pkg::STAT_ADDR_LSB +: 7]  = addr_reg;
			end
		end
		// Only the power-source bit is stored; the done bit is a pulse
		if (wr_acc && paddr == hrs_pkg::CTRL_OFS) begin
			ctrl_next[hrs_pkg::CTRL_SELF_PWR] = pwdata[hrs_pkg::CTRL_SELF_PWR];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg  <= hrs_pkg::CTRL_RST;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg   <= err_next;
		end
	end

	// ------------------------------------------------------------
	// Start-up sequencer and bus-reset handling
	// ------------------------------------------------------------
	// Timer is shared by recovery, load and apply phases
	always_comb begin
		state_next    = state_reg;
		mode_next     = mode_reg;
		timer_next    = timer_reg + 32'h0000_0001;
		released_next = 1'b1;
		start_next    = 1'b0;
		pullup_next   = pullup_reg;
		pwr_next      = pwr_reg;
		flush_next    = 1'b0;
		addr_next     = addr_reg;
		cfgd_next     = cfgd_reg;
		susp_next     = susp_reg;
		busrst_d_next = usb_bus_reset;
		green_next    = led_green_two;
		load_to_next  = load_to_reg;
		// Sticky clear comes first, so a same-cycle set below still wins
		if (wr_acc && paddr == hrs_pkg::STAT_OFS && pwdata[hrs_pkg::STAT_LOAD_TO]) begin
			load_to_next = 1'b0;
		end
		case (state_reg)
			hrs_pkg::ST_RECOVER: begin
				// Test entry caught on first edge after release
				if (!released_reg) begin
					mode_next = hrs_pkg::hrs_mode_t'(cfg_sel);
					if (factory_test_pin && cfg_sel[1] && !sclk_in) begin
						state_next = hrs_pkg::ST_TEST;
					end
				end else if (timer_reg >= 32'(RECOVERY_CYC - 1)) begin
					timer_next = 32'h0000_0000;
					// Load begins as soon as hub is operational
					if (mode_reg == hrs_pkg::MODE_MEM || mode_reg == hrs_pkg::MODE_MEM_ALT) begin
						state_next = hrs_pkg::ST_MEM_LOAD;
						start_next = 1'b1;
					end else if (mode_reg == hrs_pkg::MODE_SMB) begin
						state_next = hrs_pkg::ST_SMB_WAIT;
					end else begin
						state_next = hrs_pkg::ST_APPLY;
					end
				end
			end
			hrs_pkg::ST_MEM_LOAD: begin
				// Give up on the memory after the load limit
				if (mem_load_done || timer_reg >= 32'(LOAD_MAX_CYC - 1)) begin
					load_to_next = load_to_next | ~mem_load_done;
					state_next   = hrs_pkg::ST_APPLY;
					timer_next   = 32'h0000_0000;
				end
			end
			hrs_pkg::ST_SMB_WAIT: begin
				// Self-powered waits for the host with no limit
				if (smb_done_wr) begin
					state_next = hrs_pkg::ST_APPLY;
					timer_next = 32'h0000_0000;
				end else if (!ctrl_reg[hrs_pkg::CTRL_SELF_PWR] && timer_reg >= 32'(LOAD_MAX_CYC - 1)) begin
					// Bus-powered host overran its window; defaults are used
					load_to_next = 1'b1;
					state_next   = hrs_pkg::ST_APPLY;
					timer_next   = 32'h0000_0000;
				end
			end
			hrs_pkg::ST_APPLY: begin
				if (timer_reg >= 32'(hrs_pkg::APPLY_CYC - 1) || timer_reg >= 32'(ATTACH_MAX_CYC - 1)) begin
					state_next  = hrs_pkg::ST_ATTACHED;
					pullup_next = 1'b1;
				end
			end
			hrs_pkg::ST_ATTACHED: begin
				timer_next = timer_reg;
				if (set_addr_stb) begin
					addr_next = set_addr_val;
				end
				if (set_config_stb) begin
					cfgd_next = 1'b1;
				end
				if (suspend_req) begin
					susp_next = 1'b1;
				end
				// Host may switch ports only once configured
				pwr_next = cfgd_reg ? port_power_req : 4'h0;
				// Reset handled here only; no downstream reset output exists
				if (bus_rst_edge) begin
					addr_next  = 7'h00;
					cfgd_next  = 1'b0;
					pwr_next   = 4'h0;
					flush_next = 1'b1;
					susp_next  = 1'b0;
				end
			end
			hrs_pkg::ST_TEST: begin
				timer_next = timer_reg;
				green_next = chain_q;
			end
			default: begin
				state_next = hrs_pkg::ST_RECOVER;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= hrs_pkg::ST_RECOVER;
			mode_reg     <= hrs_pkg::MODE_STRAP;
			timer_reg    <= 32'h0000_0000;
			released_reg <= 1'b0;
			start_reg    <= 1'b0;
			pullup_reg   <= 1'b0;
			pwr_reg      <= 4'h0;
			flush_reg    <= 1'b0;
			addr_reg     <= 7'h00;
			cfgd_reg     <= 1'b0;
			susp_reg     <= 1'b0;
			busrst_d_reg <= 1'b0;
			green_reg    <= 1'b0;
			load_to_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			mode_reg     <= mode_next;
			timer_reg    <= timer_next;
			released_reg <= released_next;
			start_reg    <= start_next;
			pullup_reg   <= pullup_next;
			pwr_reg      <= pwr_next;
			flush_reg    <= flush_next;
			addr_reg     <= addr_next;
			cfgd_reg     <= cfgd_next;
			susp_reg     <= susp_next;
			busrst_d_reg <= busrst_d_next;
			green_reg    <= green_next;
			load_to_reg  <= load_to_next;
		end
	end

	// ------------------------------------------------------------
	// Host request watchdog
	// ------------------------------------------------------------
	// A request left open is ended by abort at the limit
	always_comb begin
		req_busy_next = req_busy_reg;
		req_tmr_next  = req_tmr_reg;
		abort_next    = 1'b0;
		req_to_next   = req_to_reg;
		if (req_busy_reg) begin
			req_tmr_next = req_tmr_reg + 32'h0000_0001;
			if (req_done) begin
				req_busy_next = 1'b0;
			end else if (req_tmr_reg >= 32'(REQ_MAX_CYC - 1)) begin
				req_busy_next = 1'b0;
				abort_next    = 1'b1;
				req_to_next   = 1'b1;
			end
		end else if (req_start && state_reg == hrs_pkg::ST_ATTACHED) begin
			req_busy_next = 1'b1;
			req_tmr_next  = 32'h0000_0000;
		end
		if (wr_acc && paddr == hrs_pkg::STAT_OFS && pwdata[hrs_pkg::STAT_REQ_TO] && !abort_next) begin
			req_to_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			req_busy_reg <= 1'b0;
			req_tmr_reg  <= 32'h0000_0000;
			abort_reg    <= 1'b0;
			req_to_reg   <= 1'b0;
		end else begin
			req_busy_reg <= req_busy_next;
			req_tmr_reg  <= req_tmr_next;
			abort_reg    <= abort_next;
			req_to_reg   <= req_to_next;
		end
	end

	// Outputs straight from flops
	assign prdata              = rdata_reg;
	assign pready              = ready_reg;
	assign pslverr             = err_reg;
	assign mem_load_start      = start_reg;
	assign upstream_pullup_en  = pullup_reg;
	assign port_power_enable   = pwr_reg;
	assign tt_flush            = flush_reg;
	assign req_abort           = abort_reg;
	assign dev_address         = addr_reg;
	assign green_indicator_two = green_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_pullup_after_apply: assert property ($rose(pullup_reg) |-> $past(state_reg) == hrs_pkg::ST_APPLY)
		else $error("pull-up raised before configuration applied");
	a_load_start_now: assert property (state_reg == hrs_pkg::ST_RECOVER && state_next == hrs_pkg::ST_MEM_LOAD
		|=> start_reg && state_reg == hrs_pkg::ST_MEM_LOAD)
		else $error("memory load not started on entry");
	a_load_limit: assert property (state_reg == hrs_pkg::ST_MEM_LOAD |-> timer_reg < 32'(LOAD_MAX_CYC))
		else $error("memory load overran limit");
	a_attach_limit: assert property (state_reg == hrs_pkg::ST_APPLY |-> timer_reg < 32'(ATTACH_MAX_CYC))
		else $error("attach overran limit");
	a_smb_attach: assert property (state_reg == hrs_pkg::ST_SMB_WAIT && smb_done_wr
		|=> state_reg == hrs_pkg::ST_APPLY ##[1:16] pullup_reg)
		else $error("no attach after SMBus load");
	a_smb_no_limit: assert property (state_reg == hrs_pkg::ST_SMB_WAIT && ctrl_reg[hrs_pkg::CTRL_SELF_PWR]
		&& !smb_done_wr |=> state_reg == hrs_pkg::ST_SMB_WAIT)
		else $error("self-powered SMBus wait ended early");
	a_req_limit: assert property (req_busy_reg |-> req_tmr_reg < 32'(REQ_MAX_CYC))
		else $error("request overran limit");
	a_bus_rst_addr: assert property (state_reg == hrs_pkg::ST_ATTACHED && bus_rst_edge
		|=> dev_address == 7'h00 && !cfgd_reg)
		else $error("bus reset left address or configuration");
	a_bus_rst_power: assert property (state_reg == hrs_pkg::ST_ATTACHED && bus_rst_edge
		|=> port_power_enable == 4'h0 && tt_flush && !susp_reg)
		else $error("bus reset left power, buffers or suspend");
	a_flush_cause: assert property ($rose(tt_flush) |-> $past(bus_rst_edge))
		else $error("flush without bus reset");
	a_chain_out: assert property (state_reg == hrs_pkg::ST_TEST && $past(state_reg) == hrs_pkg::ST_TEST
		|-> green_indicator_two == $past(chain_q))
		else $error("indicator not following chain");
	a_chain_toggle: assert property (state_reg == hrs_pkg::ST_TEST && $countones(test_pins ^ $past(test_pins)) == 1
		|=> chain_q != $past(chain_q))
		else $error("chain did not toggle on one pin change");

	c_mem_attach: cover property (state_reg == hrs_pkg::ST_MEM_LOAD ##[1:1000] $rose(pullup_reg));
	c_smb_attach: cover property (state_reg == hrs_pkg::ST_SMB_WAIT ##[1:1000] $rose(pullup_reg));
	c_bus_reset:  cover property (state_reg == hrs_pkg::ST_ATTACHED && cfgd_reg && bus_rst_edge);
	c_req_abort:  cover property (req_abort);
	c_test_mode:  cover property (state_reg == hrs_pkg::ST_TEST && $changed(green_indicator_two));

endmodule // hrs_sequencer

`default_nettype wire

/* File: hrs_pkg.sv */
// Purpose : Shared constants for the hub reset and configuration sequencer
// Assumes : ref_clk at 40 MHz
// Notes   : Times are kept as printed; cycle counts derive from the clock rate

package hrs_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_KHZ          = 40000;
	localparam int unsigned RECOVERY_US      = 500;   // Hub recovery after reset release
	localparam int unsigned LOAD_MAX_MS_X10  = 995;   // 99.5 ms, in tenths of a ms
	localparam int unsigned ATTACH_MAX_MS    = 100;
	localparam int unsigned REQ_MAX_MS       = 5;
	// Least and longest times round to whole cycles at 40 MHz exactly
	localparam int unsigned RECOVERY_CYC     = RECOVERY_US * CLK_KHZ / 1000;
	localparam int unsigned LOAD_MAX_CYC     = LOAD_MAX_MS_X10 * CLK_KHZ / 10;
	localparam int unsigned ATTACH_MAX_CYC   = ATTACH_MAX_MS * CLK_KHZ;
	localparam int unsigned REQ_MAX_CYC      = REQ_MAX_MS * CLK_KHZ;
	localparam int unsigned APPLY_CYC        = 16;    // Internal time to apply a loaded image

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS         = 8'h00;
	localparam logic [7:0]  STAT_OFS         = 8'h04;
	localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
	localparam int unsigned CTRL_SELF_PWR    = 0;     // 1: self-powered hub
	localparam int unsigned CTRL_SMB_DONE    = 1;     // Write 1: SMBus load finished
	localparam int unsigned STAT_LOAD_TO     = 0;     // Sticky, write 1 to clear
	localparam int unsigned STAT_REQ_TO      = 1;     // Sticky, write 1 to clear
	localparam int unsigned STAT_ATTACHED    = 2;
	localparam int unsigned STAT_CONFIGURED  = 3;
	localparam int unsigned STAT_SUSPENDED   = 4;
	localparam int unsigned STAT_TEST        = 5;
	localparam int unsigned STAT_MODE_LSB    = 8;     // Two bits of load mode
	localparam int unsigned STAT_STATE_LSB   = 12;    // Three bits of state
	localparam int unsigned STAT_ADDR_LSB    = 16;    // Seven bits of device address

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {MODE_STRAP, MODE_MEM, MODE_SMB, MODE_MEM_ALT} hrs_mode_t;
	typedef enum logic [2:0] {ST_RECOVER, ST_MEM_LOAD, ST_SMB_WAIT, ST_APPLY, ST_ATTACHED, ST_TEST} hrs_state_t;

endpackage

/* File: hrs_xnor_chain.sv */
// Purpose : Continuity chain over the tested signal pins
// Assumes : Pins are synchronous to ref_clk
// Notes   : Output is registered; any one pin change toggles it

`timescale 1ns/10ps
`default_nettype none

module hrs_xnor_chain #(
	parameter int unsigned N = 24
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic [N-1:0] test_pins,
	output var  logic         chain_out
);

	logic [N-1:0] link;
	logic         chain_reg;
	logic         chain_next;

	// ------------------------------------------------------------
	// Chain stages
	// ------------------------------------------------------------
	// One XNOR per pin after pin 0, each feeding the next
	assign link[0] = test_pins[0];
	genvar i;
	generate
		for (i = 1; i < N; i++) begin : g_stage
			assign link[i] = ~(link[i-1] ^ test_pins[i]);
		end
	endgenerate

	always_comb begin
		chain_next = link[N-1];
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chain_reg <= 1'b0;
		end else begin
			chain_reg <= chain_next;
		end
	end

	assign chain_out = chain_reg;

endmodule // hrs_xnor_chain

`default_nettype wire

/* File: hrs_far_model.sv */
// Purpose : Far-side model: configuration memory and the host's request handler
// Assumes : Answers are counted in ref_clk cycles after the start pulse
// Notes   : A delay of zero never answers, for the timeout scenarios

`timescale 1ns/10ps
`default_nettype none

module hrs_far_model (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        mem_load_start,
	input  wire logic [15:0] mem_delay,
	output var  logic        mem_load_done,
	input  wire logic        req_start,
	input  wire logic [15:0] req_delay,
	output var  logic        req_done
);
	logic [15:0] mem_cnt;
	logic [15:0] req_cnt;

	// ------------------------------------------------------------
	// Delayed answers
	// ------------------------------------------------------------
	// Done pulses last one cycle, as a real loader would give them
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_cnt <= 16'h0;
			req_cnt <= 16'h0;
			mem_load_done <= 1'b0;
			req_done <= 1'b0;
		end else begin
			mem_load_done <= (mem_cnt == 16'h1);
			req_done <= (req_cnt == 16'h1);
			mem_cnt <= mem_load_start ? mem_delay : (mem_cnt != 16'h0) ? mem_cnt - 16'h1 : 16'h0;
			req_cnt <= req_start ? req_delay : (req_cnt != 16'h0) ? req_cnt - 16'h1 : 16'h0;
		end
	end
endmodule // hrs_far_model

`default_nettype wire

/* File: tb_hub_reset_config_sequencer.sv */
// Purpose : Self-checking bench for the hub start-up sequencer
// Assumes : Shortened counts; APB answers with no wait states
// Notes   : Random values come from a fixed seed

`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module tb_hub_reset_config_sequencer;
	localparam int REC = 20;
	localparam int LD  = 200;
	localparam int ATT = 100;
	localparam int RQ  = 50;
	logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, factory_test_pin = 1'b0, sclk_in = 1'b0, usb_bus_reset = 1'b0;
	logic [1:0] cfg_sel = 2'h1;
	logic [23:0] test_pins = 24'h0;
	logic mem_load_done, set_addr_stb = 1'b0, set_config_stb = 1'b0, suspend_req = 1'b0;
	logic req_start = 1'b0, req_done, led_green_two = 1'b0, e, f, old;
	logic [6:0] set_addr_val = 7'h0, dev_address, v;
	logic [3:0] port_power_req = 4'h0;
	logic [4:1] port_power_enable;
	logic mem_load_start, upstream_pullup_en, tt_flush, req_abort, green_indicator_two;
	logic [15:0] mem_delay = 16'h1, req_delay = 16'h1;
	int err_total = 0, n_tests = 0, k, i, seed = 13805;

	always #12.5 ref_clk = ~ref_clk;

	hrs_sequencer #(.RECOVERY_CYC(REC), .LOAD_MAX_CYC(LD), .ATTACH_MAX_CYC(ATT), .REQ_MAX_CYC(RQ),
		.N_TEST(24)) uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .factory_test_pin(factory_test_pin), .cfg_sel(cfg_sel), .sclk_in(sclk_in),
		.test_pins(test_pins), .mem_load_done(mem_load_done), .usb_bus_reset(usb_bus_reset),
		.set_addr_stb(set_addr_stb), .set_addr_val(set_addr_val), .set_config_stb(set_config_stb),
		.port_power_req(port_power_req), .suspend_req(suspend_req), .req_start(req_start),
		.req_done(req_done), .led_green_two(led_green_two), .mem_load_start(mem_load_start),
		.upstream_pullup_en(upstream_pullup_en), .port_power_enable(port_power_enable),
		.tt_flush(tt_flush), .req_abort(req_abort), .dev_address(dev_address),
		.green_indicator_two(green_indicator_two));

	hrs_far_model far (.ref_clk(ref_clk), .nrst(nrst), .mem_load_start(mem_load_start),
		.mem_delay(mem_delay), .mem_load_done(mem_load_done), .req_start(req_start),
		.req_delay(req_delay), .req_done(req_done));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// In-window test for measured latencies
	function automatic logic win(input int n, input int lo, input int hi);
		return (n >= lo) && (n <= hi);
	endfunction

	// One APB transfer; waits for pready rather than assuming a latency
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
	endtask

	// Hardware reset; the low phase of 40 cycles covers one microsecond
	// reset pulse width
	task automatic hw_reset(input logic [1:0] sel, input logic tst);
		@(posedge ref_clk);
		nrst <= 1'b0; cfg_sel <= sel; factory_test_pin <= tst; sclk_in <= 1'b0; usb_bus_reset <= 1'b0;
		repeat (40) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic wait_pull(input int lim);
		k = 0;
		while (upstream_pullup_en !== 1'b1 && k < lim) begin @(posedge ref_clk); k++; end
	endtask

	task automatic pulse_req;
		@(posedge ref_clk); req_start <= 1'b1;
		@(posedge ref_clk); req_start <= 1'b0;
	endtask

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected run of under two thousand cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		err_total++;
		complete_run;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		// Both memory modes, prompt loader with a random delay
		for (i = 0; i < 2; i++) begin
			mem_delay <= 16'h1 + 16'($unsigned($random(seed)) % 128);
			hw_reset(i ? 2'b11 : 2'b01, 1'b0);
			k = 0;
			while (mem_load_start !== 1'b1 && k < REC + 10) begin @(posedge ref_clk); k++; end
			`CHK(win(k, REC - 3, REC + 2), 1'b1)
			while (mem_load_done !== 1'b1 && k < 400) begin @(posedge ref_clk); k++; end
			`CHK(upstream_pullup_en, 1'b0)
			wait_pull(ATT + 4);
			`CHK(win(k, 1, ATT), 1'b1)
		end
		// Address, configuration, power and suspend, then a bus reset
		v = 7'($random(seed)) | 7'h1;
		@(posedge ref_clk);
		set_addr_stb <= 1'b1; set_addr_val <= v; set_config_stb <= 1'b1; port_power_req <= 4'hf;
		@(posedge ref_clk);
		set_addr_stb <= 1'b0; set_config_stb <= 1'b0; suspend_req <= 1'b1;
		@(posedge ref_clk);
		suspend_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK(dev_address, v)
		`CHK(port_power_enable, 4'hf)
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[4:3], 2'b11)
		// Host waits out the attach settle time before resetting
		// host reset spacing
		repeat (ATT) @(posedge ref_clk);
		usb_bus_reset <= 1'b1;
		f = 1'b0;
		repeat (3) begin @(posedge ref_clk); f = f | tt_flush; end
		usb_bus_reset <= 1'b0;
		`CHK(f, 1'b1)
		`CHK(dev_address, 7'h0)
		`CHK(port_power_enable, 4'h0)
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[4:3], 2'b00)
		// Requests: one answered in time, one left to the watchdog
		req_delay <= 16'h8;
		pulse_req;
		f = 1'b0;
		repeat (RQ + 10) begin @(posedge ref_clk); f = f | req_abort; end
		`CHK(f, 1'b0)
		req_delay <= 16'h0;
		pulse_req;
		k = 0;
		while (req_abort !== 1'b1 && k < RQ + 10) begin @(posedge ref_clk); k++; end
		`CHK(win(k, RQ - 3, RQ + 2), 1'b1)
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[1], 1'b1)
		apb(1'b1, hrs_pkg::STAT_OFS, 32'h2);
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[1], 1'b0)
		apb(1'b0, 8'h08, 32'h0);
		`CHK({e, r}, 33'h1_0000_0000)
		// Indicator passes through outside test mode
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk); led_green_two <= ~led_green_two;
			repeat (3) @(posedge ref_clk);
			`CHK(green_indicator_two, led_green_two)
		end
		// Silent memory: the load limit ends the wait
		mem_delay <= 16'h0;
		hw_reset(2'b01, 1'b0);
		wait_pull(REC + LD + ATT + 20);
		`CHK(win(k, REC + LD, REC + LD + ATT + 4), 1'b1)
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[0], 1'b1)
		// SMBus: bus-powered host finishes early, self-powered one very late
		for (i = 0; i < 2; i++) begin
			hw_reset(2'b10, 1'b0);
			apb(1'b0, hrs_pkg::CTRL_OFS, 32'h0);
			`CHK(r, hrs_pkg::CTRL_RST)
			apb(1'b1, hrs_pkg::CTRL_OFS, 32'(i));
			repeat (i ? LD + 40 : REC + 10 + $unsigned($random(seed)) % 64) @(posedge ref_clk);
			`CHK(upstream_pullup_en, 1'b0)
			apb(1'b1, hrs_pkg::CTRL_OFS, 32'(i) | 32'h2);
			wait_pull(ATT + 4);
			`CHK(win(k, 1, ATT), 1'b1)
		end
		// Strap mode: no load, attach after recovery and apply
		hw_reset(2'b00, 1'b0);
		wait_pull(REC + ATT);
		`CHK(win(k, REC + 10, REC + 20), 1'b1)
		// Continuity test: each single pin change flips the indicator
		// test entry straps
		hw_reset(2'b10, 1'b1);
		apb(1'b0, hrs_pkg::STAT_OFS, 32'h0);
		`CHK(r[5], 1'b1)
		for (i = 0; i < 8; i++) begin
			old = green_indicator_two;
			test_pins <= test_pins ^ (24'h1 << ($unsigned($random(seed)) % 24));
			repeat (4) @(posedge ref_clk);
			`CHK(green_indicator_two, ~old)
		end
		complete_run;
	end
endmodule // tb_hub_reset_config_sequencer

`default_nettype wire
